// ===== common/fhpc_pkg.sv
// Shared constants and types for the parallel flash host pin controller.
// Assumes one 40 MHz clock; all pin timing is counted in clock cycles.
package fhpc_pkg;
    // Bus widths
    localparam int FHPC_AW = 22;
    localparam int FHPC_DW = 16;
    // Clock period in ps
    localparam int FHPC_CLK_PS = 25000;
    // Pin phase times in ns, chosen as plain defaults
    localparam int FHPC_T_SETUP_NS = 50;
    localparam int FHPC_T_STROBE_NS = 75;
    localparam int FHPC_T_HOLD_NS = 25;
    localparam int FHPC_T_RST_NS = 200;
    // Least times round up to whole cycles, at least one
    localparam int FHPC_SETUP_CYC =
        (FHPC_T_SETUP_NS * 1000 + FHPC_CLK_PS - 1) / FHPC_CLK_PS;
    localparam int FHPC_STROBE_CYC =
        (FHPC_T_STROBE_NS * 1000 + FHPC_CLK_PS - 1) / FHPC_CLK_PS;
    localparam int FHPC_HOLD_CYC =
        (FHPC_T_HOLD_NS * 1000 + FHPC_CLK_PS - 1) / FHPC_CLK_PS;
    localparam int FHPC_RST_CYC =
        (FHPC_T_RST_NS * 1000 + FHPC_CLK_PS - 1) / FHPC_CLK_PS;
    localparam int FHPC_CW = 4;
    // Sequencer states
    typedef enum logic [2:0] {
        FHPC_RESET, FHPC_IDLE, FHPC_SETUP, FHPC_STROBE, FHPC_HOLD
    } fhpc_state_e;
endpackage : fhpc_pkg

// ===== common/fhpc_pins_if.sv
// Pin-side bundle between the sequencer and the pin driver.
// Assumes both ends run on the same clock.
interface fhpc_pins_if;
    import fhpc_pkg::*;
    logic [FHPC_AW-1:0] addr;
    logic [FHPC_DW-1:0] wdata;
    logic drive;
    logic chip_sel;
    logic out_gate;
    logic wr_strobe;
    modport seq (output addr, wdata, drive, chip_sel, out_gate, wr_strobe);
    modport drv (input addr, wdata, drive, chip_sel, out_gate, wr_strobe);
endinterface : fhpc_pins_if

// ===== design/fhpc_pin_drv.sv
// Pin register stage for the flash host controller.
// Assumes the sequencer changes data and strobes in separate phases.
module fhpc_pin_drv
    import fhpc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Sequencer side
    fhpc_pins_if.drv pins,
    // Flash pins
    output logic [FHPC_AW-1:0] address_lines,
    output logic [FHPC_DW-1:0] data_lines_o,
    output logic data_lines_oe,
    output logic chip_sel_b,
    output logic out_gate_b,
    output logic wr_strobe_b
);
    logic [FHPC_AW-1:0] addr_q, addr_d;
    logic [FHPC_DW-1:0] data_q, data_d;
    logic oe_q, oe_d, cs_q, cs_d, og_q, og_d, we_q, we_d;

    // Next pin values; strobes idle high in reset
    always_comb begin
        addr_d = pins.addr;
        data_d = pins.wdata;
        oe_d = pins.drive & ~pins.out_gate; // Never fight the flash
        cs_d = ~pins.chip_sel;
        og_d = ~pins.out_gate;
        we_d = ~pins.wr_strobe;
        if (!rst_b) begin
            addr_d = '0;
            data_d = '0;
            oe_d = 1'b0;
            cs_d = 1'b1;
            og_d = 1'b1;
            we_d = 1'b1;
        end
    end

    // Glitch-free pins straight from flops
    always_ff @(posedge clk) begin
        addr_q <= addr_d;
        data_q <= data_d;
        oe_q <= oe_d;
        cs_q <= cs_d;
        og_q <= og_d;
        we_q <= we_d;
    end

    assign address_lines = addr_q;
    assign data_lines_o = data_q;
    assign data_lines_oe = oe_q;
    assign chip_sel_b = cs_q;
    assign out_gate_b = og_q;
    assign wr_strobe_b = we_q;

    // Drive and output gate never overlap
    chk_no_contention: assert property (@(posedge clk)
        disable iff (!rst_b) !(oe_q && !og_q))
        else $error("host drives data while output gate low");
endmodule // fhpc_pin_drv

// ===== design/fhpc_host.sv
// Host controller driving an asynchronous 16-bit parallel flash by pins.
// Assumes a requester on the same clock; flash data returns asynchronously.
// Operation
// - Host uses 22 address lines and 16 two-way data lines.
// - Host drives data on writes; flash drives data on reads.
// - Host holds reset low through power-up and power-down.
// - Flash latches on first rising select or strobe; host holds until then.
// - Program voltage at lockout blocks erase and program; host avoids them.
// - Host writes each command inside the targeted block; code sends req_addr as given, with no block check.
module fhpc_host
    import fhpc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [FHPC_AW-1:0] req_addr,
    input wire logic [FHPC_DW-1:0] req_wdata,
    output logic rsp_valid,
    output logic [FHPC_DW-1:0] rsp_rdata,
    output logic rsp_refused,
    // System controls
    input wire logic power_ok,
    input wire logic guard_en,
    input wire logic prog_volt_low,
    // Flash pins
    output logic [FHPC_AW-1:0] address_lines,
    input wire logic [FHPC_DW-1:0] data_lines_i,
    output logic [FHPC_DW-1:0] data_lines_o,
    output logic data_lines_oe,
    output logic chip_sel_b,
    output logic out_gate_b,
    output logic wr_strobe_b,
    output logic flash_rst_b,
    output logic lock_guard_b
);
    fhpc_pins_if pins();

    fhpc_state_e state_q, state_d;
    logic [FHPC_CW-1:0] cnt_q, cnt_d;
    logic write_q, write_d;
    logic [FHPC_AW-1:0] addr_q, addr_d;
    logic [FHPC_DW-1:0] wdata_q, wdata_d;
    logic [FHPC_DW-1:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d, refused_q, refused_d;
    logic frst_q, frst_d, guard_q, guard_d;
    logic [FHPC_DW-1:0] din_s1_q, din_s2_q;
    logic pok_s1_q, pok_s2_q, pvl_s1_q, pvl_s2_q;

    // Two-flop synchronisers for pin-side data, power_ok and prog_volt_low
    always_ff @(posedge clk) begin
        din_s1_q <= data_lines_i;
        din_s2_q <= din_s1_q;
        pok_s1_q <= power_ok;
        pok_s2_q <= pok_s1_q;
        pvl_s1_q <= prog_volt_low;
        pvl_s2_q <= pvl_s1_q;
    end

    // Phase length per state, cut to counter width
    function automatic logic [FHPC_CW-1:0] phase_len(input fhpc_state_e s);
        unique case (s)
            FHPC_SETUP: phase_len = FHPC_CW'(FHPC_SETUP_CYC - 1);
            FHPC_STROBE: phase_len = FHPC_CW'(FHPC_STROBE_CYC + 1);
            FHPC_HOLD: phase_len = FHPC_CW'(FHPC_HOLD_CYC - 1);
            default: phase_len = FHPC_CW'(FHPC_RST_CYC - 1);
        endcase
    endfunction

    assign req_ready = (state_q == FHPC_IDLE);

    // Sequencer next state; strobe extended two cycles for input sync
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        write_d = write_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        refused_d = 1'b0;
        frst_d = frst_q;
        guard_d = guard_en;
        unique case (state_q)
            FHPC_RESET: begin
                // Flash reset held low until supply is good
                frst_d = 1'b0;
                if (!pok_s2_q) begin
                    cnt_d = phase_len(FHPC_RESET);
                end else if (cnt_q == '0) begin
                    frst_d = 1'b1; // Flash returns to read array
                    state_d = FHPC_IDLE;
                end else begin
                    cnt_d = cnt_q - FHPC_CW'(1);
                end
            end
            FHPC_IDLE: begin
                if (!pok_s2_q) begin
                    frst_d = 1'b0; // Power dropping: reset first
                    cnt_d = phase_len(FHPC_RESET);
                    state_d = FHPC_RESET;
                end else if (req_valid) begin
                    if (req_write && pvl_s2_q) begin
                        // Voltage at lockout: program/erase not tried
                        refused_d = 1'b1;
                    end else begin
                        write_d = req_write;
                        addr_d = req_addr; // Command address as given
                        wdata_d = req_wdata;
                        cnt_d = phase_len(FHPC_SETUP);
                        state_d = FHPC_SETUP;
                    end
                end
            end
            FHPC_SETUP: begin
                if (cnt_q == '0) begin
                    cnt_d = phase_len(FHPC_STROBE);
                    state_d = FHPC_STROBE;
                end else begin
                    cnt_d = cnt_q - FHPC_CW'(1);
                end
            end
            FHPC_STROBE: begin
                if (cnt_q == '0) begin
                    if (!write_q) begin
                        rdata_d = din_s2_q; // Sampled while gate still low
                        rvalid_d = 1'b1;
                    end
                    cnt_d = phase_len(FHPC_HOLD);
                    state_d = FHPC_HOLD;
                end else begin
                    cnt_d = cnt_q - FHPC_CW'(1);
                end
            end
            FHPC_HOLD: begin
                if (cnt_q == '0) begin
                    rvalid_d = write_q;
                    state_d = FHPC_IDLE;
                end else begin
                    cnt_d = cnt_q - FHPC_CW'(1);
                end
            end
            default: state_d = FHPC_RESET;
        endcase
        // Supply loss aborts any access so the flash sees reset at once
        if (!pok_s2_q && state_q != FHPC_RESET) begin
            frst_d = 1'b0;
            cnt_d = phase_len(FHPC_RESET);
            state_d = FHPC_RESET;
        end
        if (!rst_b) begin
            state_d = FHPC_RESET;
            cnt_d = phase_len(FHPC_RESET);
            write_d = 1'b0;
            addr_d = '0;
            wdata_d = '0;
            rdata_d = '0;
            frst_d = 1'b0;
            guard_d = 1'b0;
        end
    end

    // Sequencer registers
    always_ff @(posedge clk) begin
        state_q <= state_d;
        cnt_q <= cnt_d;
        write_q <= write_d;
        addr_q <= addr_d;
        wdata_q <= wdata_d;
        rdata_q <= rdata_d;
        rvalid_q <= rvalid_d;
        refused_q <= refused_d;
        frst_q <= frst_d;
        guard_q <= guard_d;
    end

    // Pin intent: address and data held through strobe and hold
    assign pins.addr = addr_q;
    assign pins.wdata = wdata_q;
    assign pins.drive = write_q && (state_q != FHPC_IDLE)
        && (state_q != FHPC_RESET);
    assign pins.chip_sel = (state_q == FHPC_SETUP)
        || (state_q == FHPC_STROBE); // Standby when idle
    assign pins.out_gate = !write_q && (state_q == FHPC_STROBE);
    assign pins.wr_strobe = write_q && (state_q == FHPC_STROBE);

    fhpc_pin_drv u_drv (
        .clk(clk),
        .rst_b(rst_b),
        .pins(pins),
        .address_lines(address_lines),
        .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe),
        .chip_sel_b(chip_sel_b),
        .out_gate_b(out_gate_b),
        .wr_strobe_b(wr_strobe_b)
    );

    assign rsp_valid = rvalid_q;
    assign rsp_rdata = rdata_q;
    assign rsp_refused = refused_q;
    assign flash_rst_b = frst_q;
    assign lock_guard_b = guard_q; // Guard high releases lock-down

    // Power loss forces flash reset low within two cycles
    chk_rst_on_power: assert property (@(posedge clk)
        disable iff (!rst_b) !pok_s2_q |-> ##[1:2] !frst_q)
        else $error("flash reset not low on power loss");
    // A write under voltage lockout never starts
    chk_lockout_refuse: assert property (@(posedge clk)
        disable iff (!rst_b)
        req_valid && req_ready && req_write && pvl_s2_q && pok_s2_q
        |=> refused_q && state_q == FHPC_IDLE)
        else $error("write started under program voltage lockout");
    // Write strobe only with host driving data
    chk_strobe_data: assert property (@(posedge clk)
        disable iff (!rst_b) pins.wr_strobe |-> pins.drive && pins.chip_sel)
        else $error("strobe without driven data");
    // Address steady while chip selected
    chk_addr_hold: assert property (@(posedge clk)
        disable iff (!rst_b)
        pins.chip_sel && $past(pins.chip_sel) |-> $stable(addr_q))
        else $error("address moved during access");
    // Read gate never with write strobe
    chk_read_form: assert property (@(posedge clk)
        disable iff (!rst_b) pins.out_gate |-> !pins.wr_strobe && !pins.drive)
        else $error("read gate overlaps write");
    // Accepted request completes within 8 to 12 cycles
    chk_done_time: assert property (@(posedge clk)
        disable iff (!rst_b)
        req_valid && req_ready && !(req_write && pvl_s2_q) && pok_s2_q
        |-> ##[8:12] rsp_valid)
        else $error("access did not finish in time");
    // No access while flash held in reset
    chk_no_access_rst: assert property (@(posedge clk)
        disable iff (!rst_b) !frst_q |-> !pins.chip_sel)
        else $error("access while flash in reset");
    // Strobe lasts the full extended phase
    chk_strobe_len: assert property (@(posedge clk)
        disable iff (!rst_b) $rose(pins.chip_sel) |-> ##2 pins.chip_sel [*5])
        else $error("strobe phase too short");
endmodule // fhpc_host

// ===== sim/fhpc_flash_model.sv
// Behavioural model of the parallel flash seen from its pins.
// Assumes pin levels from the host; data bus resolved by the bench.
module fhpc_flash_model
    import fhpc_pkg::*;
(
    // Host pins
    input wire logic [FHPC_AW-1:0] address_lines,
    input wire logic [FHPC_DW-1:0] dq_in,
    input wire logic chip_sel_b,
    input wire logic out_gate_b,
    input wire logic wr_strobe_b,
    input wire logic flash_rst_b,
    // Data return and observation
    output logic [FHPC_DW-1:0] dq_out,
    output logic dq_drive,
    output logic [FHPC_AW-1:0] last_addr,
    output logic [7:0] wr_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [FHPC_DW-1:0] mem [0:255];
    logic [FHPC_DW-1:0] last_q;
    logic wr_act;
    initial begin
        wr_count = 8'h00;
        last_addr = '0;
        last_q = 16'h0000;
    end
    // Write window is select and strobe both low
    assign wr_act = !chip_sel_b && !wr_strobe_b;
    // Window closes on the first rising pin, also when both rise together
    always @(negedge wr_act) begin
        if (flash_rst_b === 1'b1) begin
            mem[address_lines[7:0]] <= dq_in;
            last_addr <= address_lines;
            wr_count <= wr_count + 8'h01;
        end
    end
    // Drive only when selected, gated and not writing
    assign dq_drive = !chip_sel_b && !out_gate_b && wr_strobe_b
        && flash_rst_b;
    // Array always readable, so read-array mode needs no command
    always_comb begin
        if (dq_drive) begin
            dq_out = mem[address_lines[7:0]];
        end else begin
            dq_out = ~last_q; // Released bus must not look stable
        end
    end
    always @(dq_out) begin
        if (dq_drive) begin
            last_q = dq_out;
        end
    end
endmodule // fhpc_flash_model

// ===== sim/tb_flash_host_bus_pin_control.sv
// Self-checking bench for the flash host pin controller.
// Assumes the flash model of this folder stands on the pins.
module tb_flash_host_bus_pin_control;
    import fhpc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0, req_write = 1'b0;
    logic [FHPC_AW-1:0] req_addr = '0;
    logic [FHPC_DW-1:0] req_wdata = '0;
    logic power_ok = 1'b0, guard_en = 1'b0, prog_volt_low = 1'b0;
    logic req_ready, rsp_valid, rsp_refused, data_lines_oe, dq_drive;
    logic chip_sel_b, out_gate_b, wr_strobe_b, flash_rst_b, lock_guard_b;
    logic [FHPC_DW-1:0] rsp_rdata, data_lines_o, flash_dq, bus;
    logic [FHPC_AW-1:0] address_lines, last_addr;
    logic [7:0] wr_count;
    int err_count = 0;
    int n_checks = 0;
    // Edges from take to answer: setup, strobe with sync, register
    localparam int RD_LAT = FHPC_SETUP_CYC + FHPC_STROBE_CYC + 3;
    localparam int WR_LAT = RD_LAT + FHPC_HOLD_CYC;
    always #12.5 clk = ~clk;
    // Host drives the wire when enabled, else the flash side
    assign bus = data_lines_oe ? data_lines_o : flash_dq;
    fhpc_host DUT (.clk(clk), .rst_b(rst_b), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
        .req_wdata(req_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .rsp_refused(rsp_refused),
        .power_ok(power_ok), .guard_en(guard_en),
        .prog_volt_low(prog_volt_low), .address_lines(address_lines),
        .data_lines_i(bus), .data_lines_o(data_lines_o),
        .data_lines_oe(data_lines_oe), .chip_sel_b(chip_sel_b),
        .out_gate_b(out_gate_b), .wr_strobe_b(wr_strobe_b),
        .flash_rst_b(flash_rst_b), .lock_guard_b(lock_guard_b));
    fhpc_flash_model flash (.address_lines(address_lines), .dq_in(bus),
        .chip_sel_b(chip_sel_b), .out_gate_b(out_gate_b),
        .wr_strobe_b(wr_strobe_b), .flash_rst_b(flash_rst_b),
        .dq_out(flash_dq), .dq_drive(dq_drive), .last_addr(last_addr),
        .wr_count(wr_count));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic timeout();
        err_count++;
        final_report();
    endtask
    // Host must never drive while the flash output gate is on
    always @(negedge clk) begin
        if (data_lines_oe === 1'b1 && out_gate_b === 1'b0) begin
            check(1, 0);
        end
    end
    // One request; returns cycles from take to answer
    task automatic access(input logic w, input logic [FHPC_AW-1:0] a,
        input logic [FHPC_DW-1:0] d, output int lat, output logic refd);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        for (n = 0; n < 50; n++) begin
            @(negedge clk);
            if (req_ready === 1'b1) break;
        end
        if (n == 50) timeout();
        @(posedge clk);
        req_valid <= 1'b0;
        // Look just after every edge from the take on; pulses last a cycle
        for (n = 0; n < 50; n++) begin
            #1;
            if (rsp_valid === 1'b1 || rsp_refused === 1'b1) break;
            @(posedge clk);
        end
        if (n == 50) timeout();
        lat = n + 1;
        refd = rsp_refused;
    endtask
    task automatic t_reset();
        int n;
        repeat (3) @(posedge clk);
        check(flash_rst_b, 0);
        check(chip_sel_b, 1);
        rst_b <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        check(flash_rst_b, 0);
        check(req_ready, 0);
        @(posedge clk);
        power_ok <= 1'b1;
        for (n = 0; n < 30; n++) begin
            @(posedge clk);
            #1;
            if (flash_rst_b === 1'b1) break;
        end
        check(n < 30, 1);
        if (n == 30) timeout();
        check(req_ready, 1);
    endtask
    // Back-to-back writes at extreme addresses, then read back
    task automatic t_write_read();
        logic [FHPC_AW-1:0] ad [2] = '{22'h3fffff, 22'h000000};
        logic [FHPC_DW-1:0] dt [2] = '{16'ha55a, 16'h5aa5};
        int lat;
        logic refd;
        for (int i = 0; i < 2; i++) begin
            access(1'b1, ad[i], dt[i], lat, refd);
            check(lat, WR_LAT);
            check(refd, 0);
            check(last_addr, ad[i]);
            check(chip_sel_b, 1);
            check(dq_drive, 0);
        end
        for (int i = 0; i < 2; i++) begin
            access(1'b0, ad[i], 16'h0000, lat, refd);
            check(lat, RD_LAT);
            check(rsp_rdata, dt[i]);
        end
    endtask
    // Writes refused under program voltage lockout, reads still served
    task automatic t_refused();
        logic [7:0] cnt;
        int lat;
        logic refd;
        @(posedge clk);
        prog_volt_low <= 1'b1;
        repeat (4) @(posedge clk);
        cnt = wr_count;
        access(1'b1, 22'h000000, 16'hffff, lat, refd);
        check(refd, 1);
        check(lat, 1);
        check(wr_count, cnt);
        access(1'b0, 22'h000000, 16'h0000, lat, refd);
        check(rsp_rdata, 16'h5aa5);
        @(posedge clk);
        prog_volt_low <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_guard();
        guard_en <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(lock_guard_b, 1);
        @(posedge clk);
        guard_en <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check(lock_guard_b, 0);
    endtask
    // Supply loss mid-run resets the flash; array reads work afterwards
    task automatic t_power_drop();
        int n;
        int lat;
        logic refd;
        @(posedge clk);
        power_ok <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        check(flash_rst_b, 0);
        check(req_ready, 0);
        @(posedge clk);
        power_ok <= 1'b1;
        for (n = 0; n < 30; n++) begin
            @(posedge clk);
            #1;
            if (req_ready === 1'b1) break;
        end
        check(n < 30, 1);
        if (n == 30) timeout();
        check(flash_rst_b, 1);
        access(1'b0, 22'h3fffff, 16'h0000, lat, refd);
        check(lat, RD_LAT);
        check(rsp_rdata, 16'ha55a);
    endtask
    initial begin
        t_reset();
        t_write_read();
        t_refused();
        t_guard();
        t_power_drop();
        repeat (5) @(posedge clk);
        final_report();
    end
endmodule // tb_flash_host_bus_pin_control
